// file: pkg/srs_pkg.sv
// Package: constants and types for the shift register sequencer
// Summary of operation
// - Shift low: parallel data loads on edge
// - Shift high: contents move right each edge
// - Ring: first three zero forces 1000 load
// - Twisted ring cycles through eight states
// - All-ones loads 0111, then shifts around
// - Detect 1011 loop, reload 0111
// - Shifter: 00 hold, 01 right, 10 left on {q_hi, q_lo}; O_WIDE gives {q_lo, q_hi}
// - Modulo feedback: xor stages 1,4 or 3,4
// - Complemented 3,4 recurrence skips all-ones
// - Load N when end state 1110 reached
// - Lock input holds counter at period end
// - All-ones treated as end-of-period state
// - Stages update on falling clock edge
// - Clear input empties all stages
package srs_pkg;
  localparam int STAGES = 4;
  localparam int WIDE = 8;
  localparam logic [3:0] RING_SEED = 4'h8;
  localparam logic [3:0] TWIST_SEED = 4'h7;
  localparam logic [3:0] TWIST_FULL = 4'hF;
  localparam logic [3:0] TWIST_BAD = 4'hB;
  localparam logic [3:0] MOD_END = 4'hE;
  localparam logic [3:0] MOD_FULL = 4'hF;
  localparam logic [3:0] CLEAR_WORD = 4'h0;
  localparam logic [7:0] WIDE_CLEAR = 8'h00;
  // Stage A is bit 3, stage D is bit 0
  localparam int ST_A = 3;
  localparam int ST_B = 2;
  localparam int ST_C = 1;
  localparam int ST_D = 0;

  typedef enum logic [3:0] {
    SRS_RING = 4'h1,
    SRS_TWIST = 4'h2,
    SRS_MOD = 4'h4,
    SRS_LR = 4'h8
  } srs_mode_type;

  typedef struct packed {
    logic load;
    logic shift;
  } srs_ctl_type;
endpackage : srs_pkg

// file: verilog/srs_top.sv
// Design: four sequencers built on two instances of one 4-bit shift stage cell
module srs_stage (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_shift,
  input wire logic i_ser,
  input wire logic [3:0] i_par,
  output logic [3:0] o_q
);
  logic [3:0] q_ff;
  wire logic [3:0] nxt_q = i_shift ? {i_ser, q_ff[3:1]} : i_par;

  // Falling edge with async clear, as the stage itself is built
  always_ff @(negedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q_ff <= srs_pkg::CLEAR_WORD;
    end else begin
      q_ff <= nxt_q;
    end
  end
  assign o_q = q_ff;

  // Stage behaviour, checked on the edge that moves the stages
  chk_stage_load: assert property (
    @(negedge i_clk) disable iff (!i_rst_b)
    !i_shift |=> (q_ff == $past(i_par))
  ) else $error("stage missed a parallel load");
  chk_stage_shift: assert property (
    @(negedge i_clk) disable iff (!i_rst_b)
    i_shift |=> (q_ff == {$past(i_ser), $past(q_ff[3:1])})
  ) else $error("stage missed a right shift");
endmodule : srs_stage

module srs_top (
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  input wire logic I_CLR_B,
  input wire srs_pkg::srs_mode_type I_MODE,
  input wire logic I_SHIFT,
  input wire logic I_LOAD,
  input wire logic I_SER,
  input wire logic I_SER_LEFT,
  input wire logic I_TAPS_AD,
  input wire logic [3:0] I_PAR,
  input wire logic [3:0] I_MOD_N,
  output logic [3:0] O_Q,
  output logic [7:0] O_WIDE,
  output logic O_END
);
  // Pins pass two flops, the reset pin one; sync reset gates the stage clear
  logic [13:0] sy1_ff;
  logic [13:0] sy2_ff;
  logic rst_ok_ff;
  // Mode is a pin too, so it is synchronised like the rest
  logic [3:0] mode_sy1_ff;
  logic [3:0] mode_sy2_ff;
  wire logic [3:0] mode_s = mode_sy2_ff;
  wire logic [13:0] raw = {I_CLR_B, I_SHIFT, I_LOAD, I_SER, I_SER_LEFT,
    I_TAPS_AD, I_PAR, I_MOD_N};
  always_ff @(posedge I_MCLK) begin
    sy1_ff <= raw;
    sy2_ff <= sy1_ff;
    rst_ok_ff <= I_RST_B;
    mode_sy1_ff <= I_MODE;
    mode_sy2_ff <= mode_sy1_ff;
  end
  wire logic clr_b = sy2_ff[13];
  wire logic s_shift = sy2_ff[12];
  wire logic s_load = sy2_ff[11];
  wire logic s_ser = sy2_ff[10];
  wire logic s_serl = sy2_ff[9];
  wire logic s_taps_ad = sy2_ff[8];
  wire logic [3:0] s_par = sy2_ff[7:4];
  wire logic [3:0] s_mod_n = sy2_ff[3:0];
  // Reset combines the bench reset with the clear pin
  wire logic stage_rst_b = rst_ok_ff & clr_b;

  logic [3:0] q;
  logic [3:0] q_hi;
  logic [3:0] q_lo;

  // Ring: first three stages zero forces the seed in
  wire logic ring_zero = (q[3:1] == 3'h0);
  wire logic ring_shift = !ring_zero;

  // Twisted ring: complemented last stage feeds first
  wire logic tw_full = (q == srs_pkg::TWIST_FULL);
  wire logic tw_bad = (q == srs_pkg::TWIST_BAD);
  wire logic tw_shift = !(tw_full || tw_bad);
  wire logic tw_ser = !q[srs_pkg::ST_D];

  // Modulo: complemented xor keeps all-ones out of the loop
  wire logic mod_tap = s_taps_ad ? q[srs_pkg::ST_A] : q[srs_pkg::ST_C];
  wire logic mod_ser = !(mod_tap ^ q[srs_pkg::ST_D]);
  wire logic mod_end = (q == srs_pkg::MOD_END) || (q == srs_pkg::MOD_FULL);
  // Lock turns the end-state load into a self reload (hold)
  wire logic [3:0] mod_par = s_load ? q : s_mod_n;
  wire logic mod_shift = !mod_end;

  // Left/right: load high with shift low means shift left
  wire logic lr_left = s_load && !s_shift;
  wire logic lr_right = !s_load && s_shift;
  wire logic [7:0] wide = {q_hi, q_lo};
  wire logic [7:0] wide_l = {wide[6:0], s_serl};
  wire logic [7:0] wide_hold = lr_left ? wide_l : wide;
  wire logic lr_shift = lr_right;

  logic main_shift;
  logic main_ser;
  logic [3:0] main_par;
  always_comb begin
    main_shift = s_shift;
    main_ser = s_ser;
    main_par = s_par;
    unique case (mode_s)
      srs_pkg::SRS_RING: begin
        main_shift = ring_shift;
        main_ser = q[srs_pkg::ST_D];
        main_par = srs_pkg::RING_SEED;
      end
      srs_pkg::SRS_TWIST: begin
        main_shift = tw_shift;
        main_ser = tw_ser;
        main_par = srs_pkg::TWIST_SEED;
      end
      srs_pkg::SRS_MOD: begin
        main_shift = mod_shift;
        main_ser = mod_ser;
        main_par = mod_par;
      end
      srs_pkg::SRS_LR: begin
        main_shift = lr_shift;
        main_ser = q_hi[0];
        main_par = wide_hold[3:0];
      end
      default: begin
        main_shift = s_shift;
        main_ser = s_ser;
        main_par = s_par;
      end
    endcase
  end
  wire logic is_lr = (mode_s == srs_pkg::SRS_LR);
  wire logic is_ring = (mode_s == srs_pkg::SRS_RING);
  wire logic is_twist = (mode_s == srs_pkg::SRS_TWIST);
  wire logic is_mod = (mode_s == srs_pkg::SRS_MOD);
  wire logic hi_shift = is_lr ? lr_shift : s_shift;
  wire logic [3:0] hi_par = is_lr ? wide_hold[7:4] : s_par;

  srs_stage u_lo (
    .i_clk(I_MCLK),
    .i_rst_b(stage_rst_b),
    .i_shift(main_shift),
    .i_ser(main_ser),
    .i_par(main_par),
    .o_q(q_lo)
  );
  // Upper stage only serves the 8-bit shifter; it feeds the low stage on right shifts
  srs_stage u_hi (
    .i_clk(I_MCLK),
    .i_rst_b(stage_rst_b),
    .i_shift(hi_shift),
    .i_ser(s_ser),
    .i_par(hi_par),
    .o_q(q_hi)
  );
  assign q = q_lo;
  assign O_Q = q_lo;
  assign O_WIDE = is_lr ? {q_lo, q_hi} : srs_pkg::WIDE_CLEAR;
  assign O_END = is_mod && mod_end;

  // Checks sample on the falling edge, before the stages move
  default clocking cb_fall @(negedge I_MCLK);
  endclocking
  default disable iff (!stage_rst_b);

  chk_ring_reload: assert property (
    is_ring && ring_zero |=> (q == srs_pkg::RING_SEED)
  ) else $error("ring did not reload its seed");
  chk_twist_full: assert property (
    is_twist && tw_full |=> (q == srs_pkg::TWIST_SEED)
  ) else $error("twisted ring missed reload after all ones");
  chk_twist_escape: assert property (
    is_twist && tw_bad |=> (q == srs_pkg::TWIST_SEED)
  ) else $error("twisted ring stayed in the unused loop");
  chk_twist_step: assert property (
    is_twist && tw_shift |=> (q == {!$past(q[0]), $past(q[3:1])})
  ) else $error("twisted ring step wrong");
  chk_mod_reload: assert property (
    is_mod && mod_end && !s_load |=> (q == $past(s_mod_n))
  ) else $error("modulo counter missed its preload");
  chk_mod_lock: assert property (
    is_mod && mod_end && s_load |=> (q == $past(q))
  ) else $error("modulo counter did not hold when locked");
  chk_mod_no_full: assert property (
    is_mod && !mod_end |=> (q != srs_pkg::MOD_FULL)
  ) else $error("modulo counter stepped into all ones");
  chk_lr_hold: assert property (
    is_lr && !s_load && !s_shift |=> (wide == $past(wide))
  ) else $error("shifter did not hold");
  chk_lr_left: assert property (
    is_lr && lr_left |=> (wide == {$past(wide[6:0]), $past(s_serl)})
  ) else $error("shifter left shift wrong");
  chk_lr_right: assert property (
    is_lr && lr_right |=> (wide == {$past(s_ser), $past(wide[7:1])})
  ) else $error("shifter right shift wrong");

  // Main scenarios that the bench is meant to reach
  cov_ring_wrap: cover property (is_ring && ring_zero ##1 q[3]);
  cov_twist_escape: cover property (is_twist && tw_bad);
  cov_mod_lock: cover property (is_mod && mod_end && s_load);
  cov_lr_left: cover property (is_lr && lr_left);
endmodule : srs_top

// file: sim/test_shift_register_sequencer.sv
// Bench: self-checking run of all four sequencer modes
module test_shift_register_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic clr_b = 1'b1;
  logic shift = 1'b0;
  logic load = 1'b0;
  logic ser = 1'b0;
  logic ser_l = 1'b0;
  logic taps = 1'b0;
  logic [3:0] par = 4'h0;
  logic [3:0] mod_n = 4'h7;
  srs_pkg::srs_mode_type mode = srs_pkg::SRS_RING;
  logic [3:0] q;
  logic [7:0] wide;
  logic lend;
  logic [3:0] exp_q[$];
  logic [3:0] s;
  int fail_count = 0;
  int n_checks = 0;
  int seed = 35;
  always #4 clk = ~clk;
  logic preset = 1'b0;
  // Noise on the preload pins, except while a start word is forced
  always @(posedge clk) par <= preset ? 4'hB : 4'($random(seed));
  srs_top srs_top_inst (.I_MCLK(clk), .I_RST_B(rst_b), .I_CLR_B(clr_b),
    .I_MODE(mode), .I_SHIFT(shift), .I_LOAD(load), .I_SER(ser),
    .I_SER_LEFT(ser_l), .I_TAPS_AD(taps), .I_PAR(par), .I_MOD_N(mod_n),
    .O_Q(q), .O_WIDE(wide), .O_END(lend));
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d fails %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic push(input logic [31:0] w);
    for (int i = 7; i >= 0; i--)
      exp_q.push_back(w[i*4+:4]);
  endtask : push
  task automatic restart(input srs_pkg::srs_mode_type m);
    rst_b <= 1'b0;
    mode <= m;
    repeat (4) @(posedge clk);
    check(q === 4'h0, "reset");
    rst_b <= 1'b1;
  endtask : restart
  task automatic drain();
    int n = 0;
    while (exp_q.size() > 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    check(exp_q.size() == 0, "stalled");
  endtask : drain
  function automatic logic [3:0] step(input logic [3:0] v);
    if (v == 4'hE || v == 4'hF) return mod_n;
    return {~((taps ? v[3] : v[1]) ^ v[0]), v[3:1]};
  endfunction : step
  // While notes remain, each new word on the low stage is matched against the oldest note
  always @(q) begin
    if (rst_b && exp_q.size() > 0)
      check(q === exp_q.pop_front(), "step");
  end
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
  initial begin
    restart(srs_pkg::SRS_RING);
    push(32'h84218421);
    drain();
    $display("ring done");
    restart(srs_pkg::SRS_TWIST);
    push(32'h8CEF7310);
    drain();
    clr_b <= 1'b0;
    repeat (5) @(posedge clk);
    check(q === 4'h0, "clear");
    push(32'h8CEF7310);
    clr_b <= 1'b1;
    drain();
    preset <= 1'b1;
    mode <= srs_pkg::srs_mode_type'(4'h0);
    repeat (6) @(posedge clk);
    check(q === 4'hB, "preset");
    push(32'h73108CEF);
    preset <= 1'b0;
    mode <= srs_pkg::SRS_TWIST;
    drain();
    $display("twist done");
    for (int i = 0; i < 4; i++) begin
      taps <= i[0];
      mod_n <= 4'h2 + 4'($unsigned($random(seed)) % 12);
      restart(srs_pkg::SRS_MOD);
      s = 4'h0;
      repeat (24) begin
        s = step(s);
        exp_q.push_back(s);
      end
      drain();
    end
    load <= 1'b1;
    restart(srs_pkg::SRS_MOD);
    repeat (40) @(posedge clk);
    check(q === 4'hE && lend === 1'b1, "lock");
    $display("modulo done");
    load <= 1'b0;
    restart(srs_pkg::SRS_LR);
    shift <= 1'b1;
    ser <= 1'b1;
    repeat (12) @(posedge clk);
    check(wide === 8'hFF, "right");
    shift <= 1'b0;
    ser <= 1'b0;
    repeat (10) @(posedge clk);
    check(wide === 8'hFF, "hold");
    load <= 1'b1;
    repeat (12) @(posedge clk);
    check(wide === 8'h00, "left");
    $display("shifter done");
    stop_test();
  end
endmodule : test_shift_register_sequencer
